// ---- ptm_defines.svh ----
`ifndef PTM_DEFINES_SVH
`define PTM_DEFINES_SVH
// Register byte addresses
`define ADDR_CTRL_A 8'h00
`define ADDR_CTRL_B 8'h04
`define ADDR_CNT_LOW 8'h08
`define ADDR_CNT_HIGH 8'h0C
`define ADDR_CMPA_LOW 8'h10
`define ADDR_CMPA_HIGH 8'h14
`define ADDR_PER_LOW 8'h18
`define ADDR_PER_HIGH 8'h1C
// Control A fields
`define CA_PAUSE_BIT 7
`define CA_CLKSEL_HI 6
`define CA_CLKSEL_LO 4
`define CA_ON_BIT 3
`define CA_MASK 8'hF8
// Control B fields
`define CB_MODE_HI 7
`define CB_MODE_LO 6
`define CB_FUNC_HI 5
`define CB_FUNC_LO 4
`define CB_LEVEL_BIT 3
`define CB_POL_BIT 2
`define CB_CAPSRC_BIT 1
`define CB_CLR_BIT 0
// Reset values
`define CTRL_RESET 8'h00
// Prescaler ratios
`define DIV_SYS 4
`define DIV_H16 16
`define DIV_H64 64
`endif

// ---- ptm_pkg.sv ----
package ptm_pkg;
    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TIMER = 2'h3
    } op_mode_t;
    typedef enum logic [2:0] {
        CLK_SYS4 = 3'h0,
        CLK_HIGH = 3'h1,
        CLK_HIGH16 = 3'h2,
        CLK_HIGH64 = 3'h3,
        CLK_TB0 = 3'h4,
        CLK_TB1 = 3'h5,
        CLK_PIN_RISE = 3'h6,
        CLK_PIN_FALL = 3'h7
    } clk_sel_t;
    // Bus slave write path state
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_RESP
    } wr_state_t;
endpackage : ptm_pkg

// ---- periodic_timer_core_regs.sv ----
`timescale 1ns/1ps
`include "ptm_defines.svh"
// Contract
// - Ten-bit up counter on selected clock source
// - Comparators A and P track counter continuously
// - Software only clears counter via on-bit rise
// - Selected match clears and raises request; overflow clears, with no request, when P is zero
// - Pause bit holds count, resume from held
// - Clock select encodes eight source choices
// - On bit runs; rise zeroes; fall keeps value
// - Compare mode: on-bit rise restores initial level
// - Mode field selects four operating modes
// - Match A sets, clears or toggles output
// - Same level as initial gives no change
// - PWM field: inactive, active, PWM, one-shot
// - Capture field: rise, fall, both, off
// - Level bit: initial or active level
// - Polarity bit inverts outputs except timer mode
// - Capture source: primary input pin or clock pin
// - Clear select picks A or P/overflow in compare and timer modes
// - Counter readable as low and high bytes
// - Unimplemented bits read zero, ignore writes
// - Compare values ten-bit, split read/write bytes
// - Low write buffered, high write commits both
// - High read latches low byte into buffer
module periodic_timer_core_regs import ptm_pkg::*; #(
    parameter int CNT_W = 10
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Prescaled internal clock enables, one-cycle pulses
    input wire logic high_clk_tick,
    input wire logic timebase_tick,
    // External pins
    input wire logic external_clock_pin,
    input wire logic pin_primary_in,
    input wire logic pin_secondary_in,
    output logic output_pin_primary,
    output logic output_pin_secondary,
    // Comparator request pulses
    output logic match_a_pulse,
    output logic match_p_pulse,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    logic [7:0] ctrl_a_reg; // Pause, clock select, on bit
    logic [7:0] ctrl_b_reg; // Mode, function, level, polarity, capture, clear
    logic [CNT_W-1:0] count_reg; // Main counter
    logic [CNT_W-1:0] cmp_a_reg; // Compare A value
    logic [CNT_W-1:0] cmp_p_reg; // Compare P value
    logic [7:0] hold_buf_reg; // Shared low-byte holding buffer
    logic on_prev_reg; // Previous on bit for edge detection
    logic pin_sync1_reg, pin_sync2_reg, pin_prev_reg; // Clock pin synchroniser
    logic capsrc_sync1_reg, capsrc_sync2_reg, capsrc_prev_reg; // Capture pin synchroniser
    logic [5:0] div_sys_reg; // System clock prescaler
    logic [5:0] div_high_reg; // High clock prescaler (counts ticks)
    logic out_level_reg; // Internal output level before polarity
    logic capture_hit; // Capture edge event, for completeness of the mode

    // Field views
    op_mode_t mode;
    clk_sel_t clk_sel;
    logic [1:0] func;
    logic timer_on, paused, on_rise;
    assign mode = op_mode_t'(ctrl_b_reg[`CB_MODE_HI:`CB_MODE_LO]);
    assign clk_sel = clk_sel_t'(ctrl_a_reg[`CA_CLKSEL_HI:`CA_CLKSEL_LO]);
    assign func = ctrl_b_reg[`CB_FUNC_HI:`CB_FUNC_LO];
    assign timer_on = ctrl_a_reg[`CA_ON_BIT];
    assign paused = ctrl_a_reg[`CA_PAUSE_BIT];
    assign on_rise = timer_on & ~on_prev_reg;

    // Synchronise the external clock pin; stage two and its delayed copy feed the edge decode
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pin_sync1_reg <= 1'b0;
            pin_sync2_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_sync1_reg <= external_clock_pin;
            pin_sync2_reg <= pin_sync1_reg;
            pin_prev_reg <= pin_sync2_reg;
        end
    end

    // Prescalers free-run so the count phase does not depend on the on bit
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            div_sys_reg <= 6'h00;
            div_high_reg <= 6'h00;
        end else begin
            div_sys_reg <= (div_sys_reg == 6'(`DIV_SYS - 1)) ? 6'h00 : div_sys_reg + 6'h01;
            if (high_clk_tick) begin
                div_high_reg <= div_high_reg + 6'h01;
            end
        end
    end

    // Clock source selection into a single count enable
    logic count_tick;
    always_comb begin
        case (clk_sel)
            CLK_SYS4: count_tick = (div_sys_reg == 6'h00);
            CLK_HIGH: count_tick = high_clk_tick;
            CLK_HIGH16: count_tick = high_clk_tick && (div_high_reg[3:0] == 4'(`DIV_H16 - 1));
            CLK_HIGH64: count_tick = high_clk_tick && (div_high_reg == 6'(`DIV_H64 - 1));
            CLK_TB0, CLK_TB1: count_tick = timebase_tick;
            CLK_PIN_RISE: count_tick = pin_sync2_reg & ~pin_prev_reg;
            CLK_PIN_FALL: count_tick = ~pin_sync2_reg & pin_prev_reg;
            default: count_tick = 1'b0;
        endcase
    end

    // Comparators compare all ten bits continuously
    logic hit_a, hit_p, overflow, clear_on_a;
    assign hit_a = (count_reg == cmp_a_reg);
    assign hit_p = (count_reg == cmp_p_reg);
    assign overflow = (count_reg == CNT_MAX);
    // Clear select only matters in compare and timer modes
    assign clear_on_a = ctrl_b_reg[`CB_CLR_BIT] && (mode == MODE_COMPARE || mode == MODE_TIMER);

    logic advance, clear_now, fire_a, fire_p;
    assign advance = timer_on && !paused && count_tick;
    assign fire_a = advance && hit_a;
    assign fire_p = advance && hit_p && !clear_on_a;
    // Clear on selected match; P of zero means wrap at overflow
    assign clear_now = advance && (clear_on_a ? hit_a :
                      (cmp_p_reg == '0 ? overflow : hit_p));

    // Main counter: no software load path; software clears it only via the on-bit rise
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
        end else if (on_rise) begin
            count_reg <= '0;
        end else if (clear_now) begin
            count_reg <= '0;
        end else if (advance) begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // One-cycle request pulses per comparator
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            match_a_pulse <= 1'b0;
            match_p_pulse <= 1'b0;
        end else begin
            match_a_pulse <= fire_a;
            match_p_pulse <= fire_p;
        end
    end

    // Capture pin chosen, then synchronised; edge decode per function field
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            capsrc_sync1_reg <= 1'b0;
            capsrc_sync2_reg <= 1'b0;
            capsrc_prev_reg <= 1'b0;
        end else begin
            capsrc_sync1_reg <= ctrl_b_reg[`CB_CAPSRC_BIT] ? external_clock_pin : pin_primary_in;
            capsrc_sync2_reg <= capsrc_sync1_reg;
            capsrc_prev_reg <= capsrc_sync2_reg;
        end
    end
    always_comb begin
        case (func)
            2'h0: capture_hit = capsrc_sync2_reg & ~capsrc_prev_reg;
            2'h1: capture_hit = ~capsrc_sync2_reg & capsrc_prev_reg;
            2'h2: capture_hit = capsrc_sync2_reg ^ capsrc_prev_reg;
            default: capture_hit = 1'b0;
        endcase
    end

    // Output level: compare actions, PWM and single pulse
    logic pulse_done_reg; // Single pulse already emitted
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            out_level_reg <= 1'b0;
            pulse_done_reg <= 1'b0;
        end else begin
            case (mode)
                MODE_COMPARE: begin
                    if (on_rise) begin
                        out_level_reg <= ctrl_b_reg[`CB_LEVEL_BIT];
                    end else if (fire_a) begin
                        case (func)
                            2'h1: out_level_reg <= 1'b0;
                            2'h2: out_level_reg <= 1'b1;
                            2'h3: out_level_reg <= ~out_level_reg;
                            default: out_level_reg <= out_level_reg;
                        endcase
                    end
                end
                MODE_PWM: begin
                    // Active level while count below duty value
                    if (on_rise) begin
                        pulse_done_reg <= 1'b0;
                    end
                    case (func)
                        2'h0: out_level_reg <= ~ctrl_b_reg[`CB_LEVEL_BIT];
                        2'h1: out_level_reg <= ctrl_b_reg[`CB_LEVEL_BIT];
                        2'h2: out_level_reg <= (timer_on && count_reg < cmp_a_reg) ?
                                               ctrl_b_reg[`CB_LEVEL_BIT] : ~ctrl_b_reg[`CB_LEVEL_BIT];
                        default: begin
                            out_level_reg <= (timer_on && !pulse_done_reg && count_reg < cmp_a_reg) ?
                                             ctrl_b_reg[`CB_LEVEL_BIT] : ~ctrl_b_reg[`CB_LEVEL_BIT];
                            if (fire_a) begin
                                pulse_done_reg <= 1'b1;
                            end
                        end
                    endcase
                end
                default: out_level_reg <= out_level_reg;
            endcase
        end
    end

    // Pins: polarity applies except in timer mode, outputs come from flops
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            output_pin_primary <= 1'b0;
            output_pin_secondary <= 1'b1;
        end else begin
            output_pin_primary <= out_level_reg ^ (ctrl_b_reg[`CB_POL_BIT] && mode != MODE_TIMER);
            output_pin_secondary <= ~(out_level_reg ^ (ctrl_b_reg[`CB_POL_BIT] && mode != MODE_TIMER));
        end
    end

    // AXI4-Lite write: take address and data in either order
    logic aw_held, w_held;
    logic [7:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    wr_state_t wr_state;
    assign s_axi_bresp = 2'h0;
    assign s_axi_rresp = 2'h0;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            wr_state <= WR_IDLE;
        end else begin
            case (wr_state)
                WR_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_held <= 1'b1;
                        aw_addr_reg <= s_axi_awaddr;
                        s_axi_awready <= 1'b0;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_held <= 1'b1;
                        w_data_reg <= s_axi_wdata[7:0];
                        w_lane0_reg <= s_axi_wstrb[0];
                        s_axi_wready <= 1'b0;
                    end
                    if (aw_held && w_held) begin
                        s_axi_bvalid <= 1'b1;
                        wr_state <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wr_state <= WR_IDLE;
                    end
                end
                default: wr_state <= WR_IDLE;
            endcase
        end
    end
    logic wr_fire;
    assign wr_fire = (wr_state == WR_IDLE) && aw_held && w_held && w_lane0_reg;

    // AXI4-Lite read: one cycle to answer, high byte reads latch low byte
    logic rd_fire;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `ADDR_CTRL_A: s_axi_rdata <= {24'h0, ctrl_a_reg};
                `ADDR_CTRL_B: s_axi_rdata <= {24'h0, ctrl_b_reg};
                `ADDR_CNT_HIGH: s_axi_rdata <= {30'h0, count_reg[9:8]};
                `ADDR_CMPA_HIGH: s_axi_rdata <= {30'h0, cmp_a_reg[9:8]};
                `ADDR_PER_HIGH: s_axi_rdata <= {30'h0, cmp_p_reg[9:8]};
                `ADDR_CNT_LOW, `ADDR_CMPA_LOW, `ADDR_PER_LOW: s_axi_rdata <= {24'h0, hold_buf_reg};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Control registers and compare pairs; writes to unused bits dropped
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_a_reg <= `CTRL_RESET;
            ctrl_b_reg <= `CTRL_RESET;
            cmp_a_reg <= '0;
            cmp_p_reg <= '0;
            on_prev_reg <= 1'b0;
        end else begin
            on_prev_reg <= timer_on;
            if (wr_fire) begin
                case (aw_addr_reg)
                    `ADDR_CTRL_A: ctrl_a_reg <= w_data_reg & `CA_MASK;
                    `ADDR_CTRL_B: ctrl_b_reg <= w_data_reg;
                    `ADDR_CMPA_HIGH: cmp_a_reg <= {w_data_reg[1:0], hold_buf_reg};
                    `ADDR_PER_HIGH: cmp_p_reg <= {w_data_reg[1:0], hold_buf_reg};
                    default: ctrl_a_reg <= ctrl_a_reg;
                endcase
            end
        end
    end

    // Shared holding buffer: compare low writes fill it, high reads latch into it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hold_buf_reg <= 8'h00;
        end else if (rd_fire && s_axi_araddr == `ADDR_CNT_HIGH) begin
            hold_buf_reg <= count_reg[7:0];
        end else if (rd_fire && s_axi_araddr == `ADDR_CMPA_HIGH) begin
            hold_buf_reg <= cmp_a_reg[7:0];
        end else if (rd_fire && s_axi_araddr == `ADDR_PER_HIGH) begin
            hold_buf_reg <= cmp_p_reg[7:0];
        end else if (wr_fire && (aw_addr_reg == `ADDR_CMPA_LOW || aw_addr_reg == `ADDR_PER_LOW)) begin
            hold_buf_reg <= w_data_reg;
        end
    end

    // Checks
    property p_on_rise_clears;
        @(posedge mclk) disable iff (reset) on_rise |=> count_reg == '0;
    endproperty
    a_on_rise_clears: assert property (p_on_rise_clears) else $error("on rise did not clear");
    property p_pause_holds;
        @(posedge mclk) disable iff (reset) (paused && !on_rise) |=> $stable(count_reg);
    endproperty
    a_pause_holds: assert property (p_pause_holds) else $error("count moved in pause");
    property p_off_holds;
        @(posedge mclk) disable iff (reset) (!timer_on && !on_rise) |=> $stable(count_reg);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("count moved while off");
    property p_clear_pulse;
        @(posedge mclk) disable iff (reset) clear_now && !on_rise |=> count_reg == '0;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear missed");
    property p_pulse_single;
        @(posedge mclk) disable iff (reset) match_a_pulse |=> !match_a_pulse;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("pulse too long");
    property p_no_p_when_a;
        @(posedge mclk) disable iff (reset) clear_on_a |=> !match_p_pulse;
    endproperty
    a_no_p_when_a: assert property (p_no_p_when_a) else $error("P pulse with A clear");
    property p_init_level;
        @(posedge mclk) disable iff (reset) (on_rise && mode == MODE_COMPARE) |=>
            out_level_reg == $past(ctrl_b_reg[`CB_LEVEL_BIT]);
    endproperty
    a_init_level: assert property (p_init_level) else $error("initial level wrong");
    property p_step_one;
        @(posedge mclk) disable iff (reset) (advance && !clear_now && !on_rise) |=>
            count_reg == $past(count_reg) + 1'b1;
    endproperty
    a_step_one: assert property (p_step_one) else $error("count step wrong");
endmodule : periodic_timer_core_regs

// ---- ptm_pin_partner.sv ----
`timescale 1ns/1ps
module ptm_pin_partner (
    // Clock
    input wire logic mclk,
    // Pins toward the timer
    output logic ext_clk,
    output logic cap_primary,
    output logic cap_secondary
);
    // Pins rest low between bursts; a free-running source would hide missed or extra edges
    initial begin
        ext_clk = 1'b0;
        cap_primary = 1'b0;
        cap_secondary = 1'b0;
    end

    // Whole pulses, each level held for several cycles so the pin synchroniser sees every edge
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge mclk);
            ext_clk <= 1'b1;
            repeat (4) @(posedge mclk);
            ext_clk <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
    endtask : burst
endmodule : ptm_pin_partner

// ---- periodic_timer_core_regs_bench.sv ----
`timescale 1ns/1ps
module periodic_timer_core_regs_bench import ptm_pkg::*;;
    // Clock, reset and design pins
    logic mclk = 1'b0, reset = 1'b1, ext_clk, cap_p, cap_s, pin_p, pin_s, m_a, m_p;
    // Internal clock enables and write lane strobes, driven by the bench
    logic hi_tick = 1'b0, tb_tick = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    // Counters for the report and the pulse monitor
    int err_count = 0, num_checks = 0, cycles = 0, a_cnt = 0, p_cnt = 0, na, np;
    logic [31:0] v;
    // Table row: optional write, optional read with expected byte
    typedef struct packed {logic [7:0] addr; logic wr; logic [7:0] wdata; logic rd; logic [7:0] exp;} row_t;
    row_t rows [9] = '{'{8'h00, 1'b1, 8'hF7, 1'b1, 8'hF0}, '{8'h04, 1'b1, 8'hA5, 1'b1, 8'hA5},
        '{8'h04, 1'b1, 8'h00, 1'b1, 8'h00}, '{8'h0C, 1'b1, 8'hFF, 1'b1, 8'h00}, '{8'h08, 1'b0, 8'h00, 1'b1, 8'h00},
        '{8'h10, 1'b1, 8'h5A, 1'b0, 8'h00}, '{8'h14, 1'b1, 8'hFF, 1'b1, 8'h03}, '{8'h10, 1'b0, 8'h00, 1'b1, 8'h5A},
        '{8'h20, 1'b1, 8'hFF, 1'b1, 8'h00}};

    // Clock of 40 ns period
    always #20 mclk = ~mclk;

    // Design under test; the internal enables and lane strobes come from the bench
    periodic_timer_core_regs periodic_timer_core_regs_i (.mclk(mclk), .reset(reset), .high_clk_tick(hi_tick),
        .timebase_tick(tb_tick), .external_clock_pin(ext_clk), .pin_primary_in(cap_p), .pin_secondary_in(cap_s),
        .output_pin_primary(pin_p), .output_pin_secondary(pin_s), .match_a_pulse(m_a), .match_p_pulse(m_p),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    // Far side: external clock and capture pins
    ptm_pin_partner ptm_pin_partner_i (.mclk(mclk), .ext_clk(ext_clk), .cap_primary(cap_p), .cap_secondary(cap_s));

    // Count one-cycle match pulses; also cut a hang short
    always @(posedge mclk) begin
        a_cnt += (m_a === 1'b1);
        p_cnt += (m_p === 1'b1);
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            test_done();
        end
    end

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // Single comparison point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Write one byte; address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h000000, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    // Read one word; data taken at the edge where rvalid is seen
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // Counter through the byte pair: high first, so the low byte comes from the buffer
    task automatic count_is(input logic [31:0] exp);
        logic [31:0] h, l;
        axi_read(8'h0C, h);
        axi_read(8'h08, l);
        check({2'b00, h[31:2] | {6'h00, l[31:8]}}, 32'h00000000);
        check({22'h000000, h[1:0], l[7:0]}, exp);
    endtask : count_is

    // Control A byte from its fields
    function automatic logic [7:0] ca(input logic pause, input clk_sel_t sel, input logic on);
        return {pause, sel, on, 3'b000};
    endfunction : ca

    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        // Register table: access kinds, reserved bits, byte pairing
        foreach (rows[i]) begin
            if (rows[i].wr) axi_write(rows[i].addr, rows[i].wdata);
            if (rows[i].rd) axi_read(rows[i].addr, v);
            if (rows[i].rd) check(v, {24'h000000, rows[i].exp});
        end
        // Write with byte lane 0 off is dropped
        wstrb <= 4'h0;
        axi_write(8'h04, 8'hFF);
        wstrb <= 4'hF;
        axi_read(8'h04, v);
        check(v, 32'h00000000);
        $display("test registers done");
        // Pin clock counting, pause, stop and restart
        axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b1));
        ptm_pin_partner_i.burst(5);
        count_is(32'd5);
        axi_write(8'h00, ca(1'b1, CLK_PIN_RISE, 1'b1));
        ptm_pin_partner_i.burst(3);
        count_is(32'd5);
        axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b1));
        ptm_pin_partner_i.burst(2);
        count_is(32'd7);
        axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b0));
        ptm_pin_partner_i.burst(2);
        count_is(32'd7);
        axi_write(8'h00, ca(1'b0, CLK_PIN_FALL, 1'b1));
        count_is(32'd0);
        ptm_pin_partner_i.burst(4);
        count_is(32'd4);
        // High clock enable for six cycles, then timebase chosen while both pulse
        axi_write(8'h00, ca(1'b0, CLK_HIGH, 1'b0));
        axi_write(8'h00, ca(1'b0, CLK_HIGH, 1'b1));
        hi_tick <= 1'b1;
        repeat (6) @(posedge mclk);
        hi_tick <= 1'b0;
        count_is(32'd6);
        axi_write(8'h00, ca(1'b0, CLK_TB1, 1'b1));
        tb_tick <= 1'b1;
        hi_tick <= 1'b1;
        repeat (3) @(posedge mclk);
        tb_tick <= 1'b0;
        repeat (2) @(posedge mclk);
        hi_tick <= 1'b0;
        count_is(32'd9);
        $display("test counting done");
        // Compare A = 2, period at its top so only A acts on the pin
        axi_write(8'h10, 8'h02);
        axi_write(8'h14, 8'h00);
        axi_write(8'h18, 8'hFF);
        axi_write(8'h1C, 8'h03);
        for (int i = 0; i < 8; i++) begin
            // Timer stopped before mode or function is touched
            axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b0));
            axi_write(8'h04, {MODE_COMPARE, i[1:0], 1'b0, i[2], 2'b00});
            axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b1));
            repeat (3) @(posedge mclk);
            check({31'h0, pin_p}, {31'h0, i[2]});
            na = a_cnt;
            ptm_pin_partner_i.burst(3);
            check(a_cnt - na, 32'd1);
            check({31'h0, pin_p}, {31'h0, i[2] ^ i[1]});
            check({31'h0, pin_s}, {31'h0, ~pin_p});
        end
        $display("test compare output done");
        // Clear select: A match alone, then P match as well
        axi_write(8'h18, 8'h02);
        axi_write(8'h1C, 8'h00);
        for (int c = 1; c >= 0; c--) begin
            axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b0));
            axi_write(8'h04, {MODE_COMPARE, 5'b00000, c[0]});
            axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b1));
            na = a_cnt;
            np = p_cnt;
            ptm_pin_partner_i.burst(3);
            check(a_cnt - na, 32'd1);
            check(p_cnt - np, {31'h0, ~c[0]});
        end
        $display("test clear select done");
        // PWM forced levels, active high; function changed only while stopped
        for (int f = 0; f < 2; f++) begin
            axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b0));
            axi_write(8'h04, {MODE_PWM, f[1:0], 1'b1, 3'b000});
            axi_write(8'h00, ca(1'b0, CLK_PIN_RISE, 1'b1));
            repeat (3) @(posedge mclk);
            check({31'h0, pin_p}, {31'h0, f[0]});
        end
        $display("test pwm levels done");
        test_done();
    end
endmodule : periodic_timer_core_regs_bench
